// ===== rtl/ebc_break_ctrl.sv
/*
  Break controller of the emulation board: decides when execution stops
  for hardware, forced, trigger and pass-count breaks.
  Assumes the core reports one fetch slot per cycle with run and skip
  flags, and stalls while HALT_REQ is high.
*/
`timescale 1ns/100ps
`default_nettype none
// Contract
// - hardware breakpoint inside a same-kind run never halts within that run.
// - such a break is deferred to the first fetch after the run ends.
// - forced and trigger breaks halt even inside a run.
// - breakpoint on a skipped instruction is ignored.
// - pass counter decrements and may halt only when instruction executes.
// - trigger break fires on the selected rising or falling edge.
// - one trigger input feeds trace-point and breakpoint logic.
module ebc_break_ctrl
  import ebc_pkg::*;
#(
  parameter int unsigned NUM_BP = EBC_NUM_BP,
  parameter int unsigned CNT_W  = EBC_CNT_W
)
(
  // clock and reset
  input  wire logic                     SYS_CLK,
  input  wire logic                     RST_N,
  // core fetch stream and host control
  input  wire ebc_fetch_t               FETCH,
  input  wire ebc_ctrl_t                CTRL,
  // breakpoint table
  input  wire logic [NUM_BP-1:0]        BP_EN,
  input  wire logic [NUM_BP*EBC_ADDR_W-1:0] BP_ADDR,
  input  wire logic [NUM_BP-1:0]        BP_LOAD,
  input  wire logic [NUM_BP*CNT_W-1:0]  BP_COUNT,
  // external trigger cable
  input  wire logic                     TRIG_IN,
  // outputs
  output logic                          HALT_REQ,
  output ebc_cause_t                    HALT_CAUSE,
  output logic [EBC_ADDR_W-1:0]         HALT_ADDR,
  output logic                          HALT_IN_RUN,
  output logic                          TRACE_TRIG
);
  ebc_state_t             state;
  ebc_state_t             next_state;
  logic                   pend;
  logic                   next_pend;
  ebc_cause_t             cause;
  ebc_cause_t             next_cause;
  logic [EBC_ADDR_W-1:0]  haddr;
  logic [EBC_ADDR_W-1:0]  next_haddr;
  logic                   hrun;
  logic                   next_hrun;
  logic                   trace;
  logic                   next_trace;
  logic                   halt;
  logic                   next_halt;
  logic [CNT_W-1:0]       cnt      [NUM_BP];
  logic [CNT_W-1:0]       next_cnt [NUM_BP];
  logic [NUM_BP-1:0]      hit;
  logic [NUM_BP-1:0]      pass_zero;
  logic                   trig_hit;
  logic                   trig_rise;
  logic                   trig_fall;
  logic                   exec;
  logic                   hw_any;
  logic                   pass_any;

  // ===========================================================
  // trigger front end
  // single shared trigger source
  ebc_trig_edge ebc_trig_edge_inst
  (
    .SYS_CLK  (SYS_CLK),
    .RST_N    (RST_N),
    .TRIG_IN  (TRIG_IN),
    .EDGE_SEL (CTRL.trig_edge),
    .RISE     (trig_rise),
    .FALL     (trig_fall),
    .HIT      (trig_hit)
  );

  // address match decode, used per breakpoint
  function automatic logic addr_match(input logic [EBC_ADDR_W-1:0] a,
                                      input logic [EBC_ADDR_W-1:0] b);
    addr_match = (a == b);
  endfunction

  // ===========================================================
  // breakpoint match and pass counters
  // skipped fetches never count as execution
  assign exec = FETCH.valid & ~FETCH.skipped & (state == EBC_ST_RUN);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BP; gi++)
    begin : g_bp
      assign hit[gi] = exec & BP_EN[gi] &
                       addr_match(FETCH.addr, BP_ADDR[gi*EBC_ADDR_W +: EBC_ADDR_W]);
      // counter of one means this pass halts; zero means plain breakpoint
      assign pass_zero[gi] = (cnt[gi] == CNT_W'(1));

      always_comb
      begin
        next_cnt[gi] = cnt[gi];
        if (BP_LOAD[gi])
          next_cnt[gi] = BP_COUNT[gi*CNT_W +: CNT_W];
        else if (hit[gi] && cnt[gi] != '0)
          next_cnt[gi] = cnt[gi] - CNT_W'(1);
      end

      always_ff @(posedge SYS_CLK or negedge RST_N)
      begin
        if (!RST_N)
          cnt[gi] <= '0;
        else
          cnt[gi] <= next_cnt[gi];
      end
    end
  endgenerate

  // plain breakpoints have count zero, pass breakpoints halt at count one
  always_comb
  begin
    hw_any   = 1'b0;
    pass_any = 1'b0;
    for (int i = 0; i < NUM_BP; i++)
    begin
      if (hit[i] && cnt[i] == '0)
        hw_any = 1'b1;
      if (hit[i] && pass_zero[i])
        pass_any = 1'b1;
    end
  end

  // ===========================================================
  // run / halt state machine
  // hazard: a deferred break is held in pend until the run ends, so a
  // later forced or trigger break may overtake it with its own cause
  always_comb
  begin
    next_state = state;
    next_pend  = pend;
    next_cause = cause;
    next_haddr = haddr;
    next_hrun  = hrun;
    next_trace = trig_rise | trig_fall;
    unique case (state)
      EBC_ST_IDLE, EBC_ST_HALTED:
      begin
        if (CTRL.go)
        begin
          next_state = EBC_ST_RUN;
          next_pend  = 1'b0;
          next_cause = EBC_CAUSE_NONE;
          next_hrun  = 1'b0;
        end
      end
      EBC_ST_RUN:
      begin
        // forced and trigger breaks ignore runs
        if (CTRL.force_brk || (CTRL.trig_en && trig_hit))
        begin
          next_state = EBC_ST_HALTED;
          next_cause = CTRL.force_brk ? EBC_CAUSE_FORCE : EBC_CAUSE_TRIG;
          next_haddr = FETCH.addr;
          // host must resume past the run
          next_hrun  = FETCH.valid & FETCH.in_run;
        end
        // deferred break lands on run exit
        else if (FETCH.valid && !FETCH.in_run && (pend || hw_any || pass_any))
        begin
          next_state = EBC_ST_HALTED;
          // a pending break keeps the cause it was armed with
          next_cause = pend ? cause : (pass_any ? EBC_CAUSE_PASS : EBC_CAUSE_HW);
          next_haddr = FETCH.addr;
          next_pend  = 1'b0;
        end
        // hits inside a run only arm the pending flag and set its cause
        else if (FETCH.valid && FETCH.in_run && (hw_any || pass_any))
        begin
          next_pend  = 1'b1;
          next_cause = pass_any ? EBC_CAUSE_PASS : EBC_CAUSE_HW;
        end
      end
      default:
        next_state = EBC_ST_IDLE;
    endcase
    // halt flag follows the state it enters, so the output is a flop
    next_halt = (next_state == EBC_ST_HALTED);
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state <= EBC_ST_IDLE;
      pend  <= 1'b0;
      cause <= EBC_CAUSE_NONE;
      haddr <= '0;
      hrun  <= 1'b0;
      trace <= 1'b0;
      halt  <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pend  <= next_pend;
      cause <= next_cause;
      haddr <= next_haddr;
      hrun  <= next_hrun;
      trace <= next_trace;
      halt  <= next_halt;
    end
  end

  // outputs straight from flops
  assign HALT_REQ    = halt;
  assign HALT_CAUSE  = cause;
  assign HALT_ADDR   = haddr;
  assign HALT_IN_RUN = hrun;
  // trace sees both edges of same input
  assign TRACE_TRIG  = trace;

  // ===========================================================
  // checks
  // no hardware halt entered inside a run
  property p_no_halt_in_run;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (state == EBC_ST_RUN && FETCH.valid && FETCH.in_run && !CTRL.force_brk && !(CTRL.trig_en && trig_hit))
      |=> (state == EBC_ST_RUN);
  endproperty
  a_no_halt_in_run: assert property (p_no_halt_in_run) else $error("halted inside a run");

  property p_defer_lands;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (state == EBC_ST_RUN && pend && FETCH.valid && !FETCH.in_run)
      |=> (HALT_REQ && HALT_ADDR == $past(FETCH.addr));
  endproperty
  a_defer_lands: assert property (p_defer_lands) else $error("deferred break missed run exit");

  property p_force_halts;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (state == EBC_ST_RUN && CTRL.force_brk) |=> (HALT_REQ && HALT_CAUSE == EBC_CAUSE_FORCE);
  endproperty
  a_force_halts: assert property (p_force_halts) else $error("forced break ignored");

  property p_run_flag;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (state == EBC_ST_RUN && CTRL.force_brk) |=> (HALT_IN_RUN == $past(FETCH.valid & FETCH.in_run));
  endproperty
  a_run_flag: assert property (p_run_flag) else $error("run flag wrong at break");

  property p_skip_ignored;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (state == EBC_ST_RUN && FETCH.valid && FETCH.skipped && !pend && !CTRL.force_brk && !(CTRL.trig_en && trig_hit))
      |=> (state == EBC_ST_RUN);
  endproperty
  a_skip_ignored: assert property (p_skip_ignored) else $error("skipped instruction halted");

  property p_pass_skip;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (FETCH.skipped && BP_LOAD == '0) |=> (cnt[0] == $past(cnt[0]));
  endproperty
  a_pass_skip: assert property (p_pass_skip) else $error("pass count moved on skip");

  property p_trig_halts;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (state == EBC_ST_RUN && CTRL.trig_en && trig_hit && !CTRL.force_brk)
      |=> (HALT_REQ && HALT_CAUSE == EBC_CAUSE_TRIG);
  endproperty
  a_trig_halts: assert property (p_trig_halts) else $error("trigger edge ignored");

  property p_trace_shared;
    @(posedge SYS_CLK) disable iff (!RST_N)
      trig_hit |=> TRACE_TRIG;
  endproperty
  a_trace_shared: assert property (p_trace_shared) else $error("trace missed trigger edge");
endmodule
`default_nettype wire

// ===== shared/ebc_pkg.sv
/*
  Package for the emulator break controller: widths, edge-select codes,
  state encoding and the carrier structs for fetch and control inputs.
  Assumes one synchronous system clock and a fetch stream from the core.
*/
`default_nettype none
package ebc_pkg;
  // ===========================================================
  // widths and defaults
  localparam int unsigned EBC_ADDR_W     = 12;
  localparam int unsigned EBC_NUM_BP     = 4;
  localparam int unsigned EBC_CNT_W      = 8;
  localparam logic        EBC_EDGE_RISE  = 1'b0;
  localparam logic        EBC_EDGE_FALL  = 1'b1;

  // ===========================================================
  // break cause codes
  typedef enum logic [2:0]
  {
    EBC_CAUSE_NONE  = 3'b000,
    EBC_CAUSE_HW    = 3'b001,
    EBC_CAUSE_FORCE = 3'b010,
    EBC_CAUSE_TRIG  = 3'b011,
    EBC_CAUSE_PASS  = 3'b100
  } ebc_cause_t;

  // run state
  typedef enum logic [1:0]
  {
    EBC_ST_IDLE   = 2'b00,
    EBC_ST_RUN    = 2'b01,
    EBC_ST_HALTED = 2'b10
  } ebc_state_t;

  // ===========================================================
  // one fetch slot reported by the core
  typedef struct packed
  {
    logic                  valid;    // fetch happened this cycle
    logic [EBC_ADDR_W-1:0] addr;     // address fetched
    logic                  in_run;   // fetch is inside a same-kind run
    logic                  skipped;  // instruction skipped by a skip op
  } ebc_fetch_t;

  // host control inputs
  typedef struct packed
  {
    logic go;        // start a run, one-cycle pulse
    logic force_brk; // forced break request, one-cycle pulse
    logic trig_en;   // trigger break enabled
    logic trig_edge; // 0 rising, 1 falling
  } ebc_ctrl_t;
endpackage
`default_nettype wire

// ===== rtl/ebc_trig_edge.sv
/*
  Trigger input synchroniser and edge detector.
  Assumes the trigger cable is asynchronous to the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module ebc_trig_edge
  import ebc_pkg::*;
(
  // clock and reset
  input  wire logic SYS_CLK,
  input  wire logic RST_N,
  // trigger
  input  wire logic TRIG_IN,
  input  wire logic EDGE_SEL,
  output logic      RISE,
  output logic      FALL,
  output logic      HIT
);
  logic sync1;
  logic sync2;
  logic prev;
  logic next_sync1;
  logic next_sync2;
  logic next_prev;

  // ===========================================================
  // two-flop synchroniser, then one history flop
  always_comb
  begin
    next_sync1 = TRIG_IN;
    next_sync2 = sync1;
    next_prev  = sync2;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev  <= 1'b0;
    end
    else
    begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev  <= next_prev;
    end
  end

  assign RISE = sync2 & ~prev;
  assign FALL = ~sync2 & prev;
  assign HIT  = (EDGE_SEL == EBC_EDGE_FALL) ? FALL : RISE;

  property p_edge_cause;
    @(posedge SYS_CLK) disable iff (!RST_N)
      HIT |-> (sync2 != prev);
  endproperty
  a_edge_cause: assert property (p_edge_cause) else $error("edge without sample change");
endmodule
`default_nettype wire

// ===== tb/ebc_trig_cable.sv
/*
  Behavioural model of the external trace cable that drives the trigger.
  Assumes the bench sets the wanted level; the cable adds its own skew.
*/
`timescale 1ns/100ps
`default_nettype none
module ebc_trig_cable
(
  // level wanted by the bench
  input  wire logic LEVEL_REQ,
  // line into the break controller
  output wire logic TRIG
);
  // ==========================================================
  // skewed line: lands off the clock grid, so the sync stage is exercised
  // one shared line
  assign #3.3 TRIG = LEVEL_REQ;
endmodule
`default_nettype wire

// ===== tb/tb_emulator_break_control.sv
/*
  Self-checking bench for the break controller, one task per scenario.
  Assumes the cable model in ebc_trig_cable and default parameter values.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_emulator_break_control
  import ebc_pkg::*;
;
  logic SYS_CLK = 1'b0;
  logic RST_N   = 1'b0;
  ebc_fetch_t fetch_in = '0;
  ebc_ctrl_t  ctrl     = '0;
  logic [3:0]  bp_en   = '0;
  logic [47:0] bp_addr = '0;
  logic [3:0]  bp_load = '0;
  logic [31:0] bp_count = '0;
  logic trig_level = 1'b0;
  logic trig_line;
  logic HALT_REQ, HALT_IN_RUN, TRACE_TRIG;
  ebc_cause_t HALT_CAUSE;
  logic [11:0] HALT_ADDR;
  int miscompares = 0;
  int cmp_count = 0;
  int trace_seen = 0;

  // ==========================================================
  // clock and instances
  always #5 SYS_CLK = ~SYS_CLK;
  ebc_trig_cable ebc_trig_cable_inst (.LEVEL_REQ(trig_level), .TRIG(trig_line));
  ebc_break_ctrl ebc_break_ctrl_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .FETCH(fetch_in),
    .CTRL(ctrl), .BP_EN(bp_en), .BP_ADDR(bp_addr), .BP_LOAD(bp_load), .BP_COUNT(bp_count),
    .TRIG_IN(trig_line), .HALT_REQ(HALT_REQ), .HALT_CAUSE(HALT_CAUSE), .HALT_ADDR(HALT_ADDR),
    .HALT_IN_RUN(HALT_IN_RUN), .TRACE_TRIG(TRACE_TRIG));
  // trace pulses are counted apart from breaks
  always @(posedge SYS_CLK)
    if (TRACE_TRIG === 1'b1)
      trace_seen++;

  // ==========================================================
  // shared bus-side tasks
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one breakpoint enabled at a time, counter loaded with it
  task automatic set_bp(input int i, input logic [11:0] a, input logic [7:0] c);
    @(posedge SYS_CLK);
    bp_en <= 4'h1 << i;
    bp_addr[i*12 +: 12] <= a;
    bp_count[i*8 +: 8] <= c;
    bp_load <= 4'h1 << i;
    @(posedge SYS_CLK);
    bp_load <= '0;
  endtask
  task automatic go();
    @(posedge SYS_CLK);
    ctrl.go <= 1'b1;
    @(posedge SYS_CLK);
    ctrl.go <= 1'b0;
  endtask
  task automatic fetch(input logic [11:0] a, input logic r, input logic s);
    @(posedge SYS_CLK);
    fetch_in <= '{valid: 1'b1, addr: a, in_run: r, skipped: s};
  endtask
  task automatic idle();
    @(posedge SYS_CLK);
    fetch_in <= '0;
  endtask
  // bounded wait; expect_halt 0 means the window must stay quiet
  task automatic wait_halt(input logic expect_halt, input ebc_cause_t c);
    int n;
    n = 0;
    // step off the edge so outputs launched on it have settled
    #1;
    while (n < 8 && HALT_REQ !== 1'b1)
    begin
      @(posedge SYS_CLK);
      #1;
      n++;
    end
    `CHK(HALT_REQ, expect_halt)
    if (expect_halt && HALT_REQ !== 1'b1)
      conclude();
    if (expect_halt)
      `CHK(HALT_CAUSE, c)
  endtask

  // ==========================================================
  // scenarios
  task automatic sc_run_defer();
    set_bp(0, 12'h0101, 8'h00);
    go();
    fetch(12'h0100, 1'b1, 1'b0);
    fetch(12'h0101, 1'b1, 1'b0);
    fetch(12'h0102, 1'b1, 1'b0);
    fetch(12'h0103, 1'b0, 1'b0);
    idle();
    wait_halt(1'b1, EBC_CAUSE_HW);
    `CHK(HALT_ADDR, 12'h0103)
    `CHK(HALT_IN_RUN, 1'b0)
  endtask
  task automatic sc_force_in_run();
    @(posedge SYS_CLK);
    bp_en <= '0;
    go();
    fetch(12'h0200, 1'b1, 1'b0);
    ctrl.force_brk <= 1'b1;
    fetch(12'h0201, 1'b1, 1'b0);
    ctrl.force_brk <= 1'b0;
    idle();
    wait_halt(1'b1, EBC_CAUSE_FORCE);
    `CHK(HALT_IN_RUN, 1'b1)
    // host resumes past the run end
    go();
    fetch(12'h0203, 1'b0, 1'b0);
    idle();
    wait_halt(1'b0, EBC_CAUSE_NONE);
  endtask
  task automatic sc_skip();
    set_bp(1, 12'h0300, 8'h00);
    go();
    fetch(12'h0300, 1'b0, 1'b1);
    idle();
    wait_halt(1'b0, EBC_CAUSE_NONE);
    fetch(12'h0300, 1'b0, 1'b0);
    idle();
    wait_halt(1'b1, EBC_CAUSE_HW);
  endtask
  task automatic sc_pass();
    // slot zero, so the skip check on its counter sees a live count
    set_bp(0, 12'h0400, 8'h02);
    go();
    fetch(12'h0400, 1'b0, 1'b1);
    fetch(12'h0400, 1'b0, 1'b0);
    idle();
    wait_halt(1'b0, EBC_CAUSE_NONE);
    fetch(12'h0400, 1'b0, 1'b0);
    idle();
    wait_halt(1'b1, EBC_CAUSE_PASS);
    `CHK(HALT_ADDR, 12'h0400)
  endtask
  // sel picks the edge; the opposite edge must only pulse the trace output
  // a move to level sel is the opposite edge, a move to ~sel the chosen one
  task automatic sc_trig(input logic sel);
    int t0;
    @(posedge SYS_CLK);
    bp_en <= '0;
    trig_level <= ~sel;
    repeat (6) @(posedge SYS_CLK);
    ctrl.trig_en <= 1'b1;
    ctrl.trig_edge <= sel;
    go();
    t0 = trace_seen;
    trig_level <= sel;
    wait_halt(1'b0, EBC_CAUSE_NONE);
    trig_level <= ~sel;
    wait_halt(1'b1, EBC_CAUSE_TRIG);
    // the trace pulse of the halting edge is counted one edge later
    @(posedge SYS_CLK);
    #1;
    `CHK(trace_seen - t0, 2)
    @(posedge SYS_CLK);
    ctrl.trig_en <= 1'b0;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    sc_run_defer();
    sc_force_in_run();
    sc_skip();
    sc_pass();
    sc_trig(EBC_EDGE_RISE);
    sc_trig(EBC_EDGE_FALL);
    conclude();
  end
endmodule
`default_nettype wire
